// ===== design/hstw_top.v
// What this block does
// - Normal mode counts zero to top, restarts
// - Normal toggle inverts output on each match
// - Normal: clear on match, inverting sets
// - Counter clears on the tick after top
// - Normal overflow sets when counter becomes zero
// - Software may write the counter anytime
// - Normal: complement pin off, true pin if nonzero
// - PWM with slope bit 0 is fast PWM
// - Fast non-inverting: clear on match, set at zero
// - Fast inverting: set on match, clear at zero
// - Fast complementary gives both true and inverted
// - Fast PWM overflow sets on reaching top
// - Setting two non-inverted, three inverted PWM
// - Compare zero spikes, compare equal to top gives constant
// - Fast setting one gives the same waveform as setting two
// - Pin shows compare only if set and output
// - Fast: 01 both pins, 10/11 true only
// - PWM with slope bit 1 counts up, down
// - Normal toggle frequency is clock over 2(1+top)
// - Dual: clear on up match, set on down
// - Dual slope holds top for one tick
// - Dual slope overflow sets at zero
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "hstw_map.vh"
module hstw_top #(
    parameter TW = 10,
    parameter CH = 3,
    parameter PW = 16
) (
    input wire aclk, // System clock, 40 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte enables
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    output reg [CH-1:0] pin_true_o, // True pin level
    output reg [CH-1:0] pin_true_oe, // True pin driven
    output reg [CH-1:0] pin_comp_o, // Complementary pin level
    output reg [CH-1:0] pin_comp_oe, // Complementary pin driven
    output reg [CH-1:0] waveform_out, // Waveform to dead-time stage
    output reg overflow_flag // Overflow flag
);
    reg pwm_select_r;
    reg slope_select_r;
    reg run_r;
    reg [TW-1:0] timer_count_r;
    reg [TW-1:0] timer_count_nxt;
    reg count_up_r;
    reg count_up_nxt;
    reg ovf_set;
    reg [TW-1:0] top_value_reg_r;
    reg [PW-1:0] presc_r;
    reg [CH-1:0] port_true_r;
    reg [CH-1:0] port_comp_r;
    reg [CH-1:0] dir_true_r;
    reg [CH-1:0] dir_comp_r;
    reg [TW-1:0] channel_compare_reg_r [0:CH-1];
    reg [1:0] output_setting_r [0:CH-1];
    reg [CH-1:0] compare_pin_out_r;
    reg [7:0] awaddr_r;
    reg aw_held_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_held_r;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg wr_hit;
    reg wr_cnt;
    reg [31:0] wmask;
    reg [31:0] wval;
    wire timer_clock;
    wire wr_go;
    wire [CH-1:0] wave;
    integer i, i_dec, i_rd, i_pin; // One loop index per process

    hstw_presc #(
        .W(PW)
    ) u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run_r),
        .div(presc_r),
        .tick(timer_clock)
    );

    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1) begin : g_chan
            hstw_chan #(
                .TW(TW)
            ) u_chan (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(timer_clock),
                .count(timer_count_r),
                .top(top_value_reg_r),
                .cmp(channel_compare_reg_r[g]),
                .setting(output_setting_r[g]),
                .pwm_select(pwm_select_r),
                .slope_select(slope_select_r),
                .count_up(count_up_r),
                .wave(wave[g])
            );
        end
    endgenerate

    // Counting sequence on each timer clock tick
    always @* begin
        timer_count_nxt = timer_count_r;
        count_up_nxt = count_up_r;
        ovf_set = 1'b0;
        if (timer_clock) begin
            if (!(pwm_select_r && slope_select_r)) begin
                count_up_nxt = 1'b1;
                if (timer_count_r == top_value_reg_r) begin
                    timer_count_nxt = {TW{1'b0}};
                    ovf_set = !pwm_select_r;
                end else begin
                    timer_count_nxt = timer_count_r + {{(TW-1){1'b0}}, 1'b1};
                end
                // Fast PWM flags on arrival at top, not on the wrap
                if (pwm_select_r && timer_count_nxt == top_value_reg_r)
                    ovf_set = 1'b1;
            end else if (top_value_reg_r == {TW{1'b0}}) begin
                // Degenerate dual slope: nothing to count between ends
                timer_count_nxt = {TW{1'b0}};
                ovf_set = 1'b1;
            end else if (count_up_r) begin
                if (timer_count_r >= top_value_reg_r) begin
                    // Top already held for this tick, turn round
                    count_up_nxt = 1'b0;
                    timer_count_nxt = timer_count_r - {{(TW-1){1'b0}}, 1'b1};
                end else begin
                    timer_count_nxt = timer_count_r + {{(TW-1){1'b0}}, 1'b1};
                end
            end else if (timer_count_r == {TW{1'b0}}) begin
                count_up_nxt = 1'b1;
                timer_count_nxt = {{(TW-1){1'b0}}, 1'b1};
            end else begin
                timer_count_nxt = timer_count_r - {{(TW-1){1'b0}}, 1'b1};
                if (timer_count_nxt == {TW{1'b0}})
                    ovf_set = 1'b1;
            end
        end
    end

    // Write side decode
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

    always @* begin
        wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                 {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        wval = wdata_r & wmask;
        wr_hit = 1'b0;
        wr_cnt = 1'b0;
        case (awaddr_r)
            `HSTW_OFF_CTRL, `HSTW_OFF_STAT, `HSTW_OFF_TOP,
            `HSTW_OFF_PRESC, `HSTW_OFF_PORT, `HSTW_OFF_DIR: wr_hit = 1'b1;
            `HSTW_OFF_CNT: begin
                wr_hit = 1'b1;
                wr_cnt = 1'b1;
            end
            default: wr_hit = 1'b0;
        endcase
        for (i_dec = 0; i_dec < CH; i_dec = i_dec + 1) begin
            if (awaddr_r == `HSTW_OFF_CMP0 + i_dec * 4)
                wr_hit = 1'b1;
        end
    end

    // AXI4-Lite write channel and register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HSTW_RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            pwm_select_r <= 1'b0;
            slope_select_r <= 1'b0;
            run_r <= 1'b0;
            top_value_reg_r <= `HSTW_RST_TOP;
            presc_r <= `HSTW_RST_PRESC;
            port_true_r <= {CH{1'b0}};
            port_comp_r <= {CH{1'b0}};
            dir_true_r <= {CH{1'b0}};
            dir_comp_r <= {CH{1'b0}};
            overflow_flag <= 1'b0;
            timer_count_r <= {TW{1'b0}};
            count_up_r <= 1'b1;
            for (i = 0; i < CH; i = i + 1) begin
                channel_compare_reg_r[i] <= {TW{1'b0}};
                output_setting_r[i] <= 2'h0;
            end
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                aw_held_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_held_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            // Set wins over a software clear in the same cycle
            overflow_flag <= ovf_set | overflow_flag;
            // A software count write overrides the tick
            timer_count_r <= timer_count_nxt;
            count_up_r <= count_up_nxt;
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `HSTW_RESP_OKAY : `HSTW_RESP_SLVERR;
                case (awaddr_r)
                    `HSTW_OFF_CTRL: begin
                        if (wstrb_r[0]) begin
                            pwm_select_r <= wdata_r[`HSTW_CTRL_PWM];
                            slope_select_r <= wdata_r[`HSTW_CTRL_SLOPE];
                            run_r <= wdata_r[`HSTW_CTRL_RUN];
                        end
                    end
                    `HSTW_OFF_STAT: begin
                        if (wval[`HSTW_STAT_OVF] && !ovf_set)
                            overflow_flag <= 1'b0;
                    end
                    `HSTW_OFF_TOP:
                        top_value_reg_r <= (top_value_reg_r & ~wmask[TW-1:0])
                            | wval[TW-1:0];
                    `HSTW_OFF_PRESC:
                        presc_r <= (presc_r & ~wmask[PW-1:0]) | wval[PW-1:0];
                    `HSTW_OFF_PORT: begin
                        if (wstrb_r[0])
                            port_true_r <= wdata_r[CH-1:0];
                        if (wstrb_r[1])
                            port_comp_r <= wdata_r[`HSTW_PORT_COMP+CH-1:
                                                   `HSTW_PORT_COMP];
                    end
                    `HSTW_OFF_DIR: begin
                        if (wstrb_r[0])
                            dir_true_r <= wdata_r[CH-1:0];
                        if (wstrb_r[1])
                            dir_comp_r <= wdata_r[`HSTW_PORT_COMP+CH-1:
                                                  `HSTW_PORT_COMP];
                    end
                    default: begin
                    end
                endcase
                if (wr_cnt) begin
                    timer_count_r <= (timer_count_r & ~wmask[TW-1:0])
                        | wval[TW-1:0];
                end
                for (i = 0; i < CH; i = i + 1) begin
                    if (awaddr_r == `HSTW_OFF_CMP0 + i * 4) begin
                        channel_compare_reg_r[i] <=
                            (channel_compare_reg_r[i] & ~wmask[TW-1:0])
                            | wval[TW-1:0];
                        if (wstrb_r[2])
                            output_setting_r[i] <=
                                wdata_r[`HSTW_CMP_SET+1:`HSTW_CMP_SET];
                    end
                end
            end
        end
    end

    // Read data selection
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `HSTW_OFF_CTRL: begin
                rd_mux[`HSTW_CTRL_PWM] = pwm_select_r;
                rd_mux[`HSTW_CTRL_SLOPE] = slope_select_r;
                rd_mux[`HSTW_CTRL_RUN] = run_r;
            end
            `HSTW_OFF_STAT: begin
                rd_mux[`HSTW_STAT_OVF] = overflow_flag;
                rd_mux[`HSTW_STAT_DOWN] = !count_up_r;
                rd_mux[`HSTW_STAT_WAVE+CH-1:`HSTW_STAT_WAVE] = waveform_out;
            end
            `HSTW_OFF_CNT: rd_mux[TW-1:0] = timer_count_r;
            `HSTW_OFF_TOP: rd_mux[TW-1:0] = top_value_reg_r;
            `HSTW_OFF_PRESC: rd_mux[PW-1:0] = presc_r;
            `HSTW_OFF_PORT: begin
                rd_mux[CH-1:0] = port_true_r;
                rd_mux[`HSTW_PORT_COMP+CH-1:`HSTW_PORT_COMP] = port_comp_r;
            end
            `HSTW_OFF_DIR: begin
                rd_mux[CH-1:0] = dir_true_r;
                rd_mux[`HSTW_PORT_COMP+CH-1:`HSTW_PORT_COMP] = dir_comp_r;
            end
            default: rd_hit = 1'b0;
        endcase
        for (i_rd = 0; i_rd < CH; i_rd = i_rd + 1) begin
            if (s_axi_araddr == `HSTW_OFF_CMP0 + i_rd * 4) begin
                rd_hit = 1'b1;
                rd_mux[TW-1:0] = channel_compare_reg_r[i_rd];
                rd_mux[`HSTW_CMP_SET+1:`HSTW_CMP_SET] = output_setting_r[i_rd];
            end
        end
    end

    // AXI4-Lite read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HSTW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `HSTW_RESP_OKAY : `HSTW_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Compare output lags the waveform by one timer clock, then pin muxing
    always @(posedge aclk) begin
        if (!aresetn) begin
            compare_pin_out_r <= {CH{1'b0}};
            waveform_out <= {CH{1'b0}};
            pin_true_o <= {CH{1'b0}};
            pin_true_oe <= {CH{1'b0}};
            pin_comp_o <= {CH{1'b0}};
            pin_comp_oe <= {CH{1'b0}};
        end else begin
            waveform_out <= wave;
            if (timer_clock)
                compare_pin_out_r <= waveform_out;
            for (i_pin = 0; i_pin < CH; i_pin = i_pin + 1) begin
                // Direction alone enables the driver; setting picks source
                pin_true_oe[i_pin] <= dir_true_r[i_pin];
                pin_comp_oe[i_pin] <= dir_comp_r[i_pin];
                if (output_setting_r[i_pin] != 2'h0)
                    pin_true_o[i_pin] <= compare_pin_out_r[i_pin];
                else
                    pin_true_o[i_pin] <= port_true_r[i_pin];
                if (pwm_select_r && output_setting_r[i_pin] == 2'h1)
                    pin_comp_o[i_pin] <= ~compare_pin_out_r[i_pin];
                else
                    pin_comp_o[i_pin] <= port_comp_r[i_pin];
            end
        end
    end
endmodule // hstw_top

// ===== design/hstw_map.vh
// Register offsets, field positions and reset values of the timer block
`ifndef HSTW_MAP_VH
`define HSTW_MAP_VH

`define HSTW_OFF_CTRL 8'h00
`define HSTW_OFF_STAT 8'h04
`define HSTW_OFF_CNT 8'h08
`define HSTW_OFF_TOP 8'h0C
`define HSTW_OFF_PRESC 8'h10
`define HSTW_OFF_PORT 8'h14
`define HSTW_OFF_DIR 8'h18
`define HSTW_OFF_CMP0 8'h20

`define HSTW_CTRL_PWM 0
`define HSTW_CTRL_SLOPE 1
`define HSTW_CTRL_RUN 2

`define HSTW_STAT_OVF 0
`define HSTW_STAT_DOWN 1
`define HSTW_STAT_WAVE 8
`define HSTW_PORT_COMP 8
`define HSTW_CMP_SET 16

`define HSTW_RST_TOP 10'h3FF
`define HSTW_RST_PRESC 16'h0000

`define HSTW_RESP_OKAY 2'h0
`define HSTW_RESP_SLVERR 2'h2

`endif

// ===== design/hstw_presc.v
// Prescaler that makes the timer clock tick from the system clock
`timescale 1ns/1ps
module hstw_presc #(
    parameter W = 16
) (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire run, // Timer enabled
    input wire [W-1:0] div, // Tick every div+1 clocks
    output reg tick // One-cycle timer clock tick
);
    reg [W-1:0] cnt_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= {W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            cnt_r <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_r >= div) begin
            // Compare with >= so a smaller divider never waits a full wrap
            cnt_r <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule // hstw_presc

// ===== design/hstw_chan.v
// One compare channel: match detection and waveform output
`timescale 1ns/1ps
module hstw_chan #(
    parameter TW = 10
) (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire tick, // Timer clock tick
    input wire [TW-1:0] count, // Present timer count
    input wire [TW-1:0] top, // Top value
    input wire [TW-1:0] cmp, // Channel compare value
    input wire [1:0] setting, // Output setting
    input wire pwm_select, // 0 normal, 1 PWM
    input wire slope_select, // 0 single slope, 1 dual slope
    input wire count_up, // Dual slope direction
    output reg wave // Waveform output
);
    wire match;
    wire bottom;

    assign match = tick && (count == cmp);
    // Single slope returns to zero on the tick after top
    assign bottom = tick && (count == top) && !slope_select;

    always @(posedge aclk) begin
        if (!aresetn) begin
            wave <= 1'b0;
        end else if (!pwm_select) begin
            if (match) begin
                case (setting)
                    2'h1: wave <= ~wave;
                    2'h2: wave <= 1'b0;
                    2'h3: wave <= 1'b1;
                    default: wave <= wave;
                endcase
            end
        end else if (!slope_select) begin
            // Match wins over bottom so a compare equal to top gives a constant level
            case (setting)
                2'h1, 2'h2: begin
                    if (match)
                        wave <= 1'b0;
                    else if (bottom)
                        wave <= 1'b1;
                end
                2'h3: begin
                    if (match)
                        wave <= 1'b1;
                    else if (bottom)
                        wave <= 1'b0;
                end
                default: wave <= wave;
            endcase
        end else if (match) begin
            case (setting)
                2'h1, 2'h2: wave <= !count_up;
                2'h3: wave <= count_up;
                default: wave <= wave;
            endcase
        end
    end
endmodule // hstw_chan

// ===== sim/hstw_assertions.sv
// Bus and flag checker for the timer waveform block
`timescale 1ns/1ps
module hstw_assertions #(
    parameter CH = 3
) (
    input logic aclk, // Clock
    input logic aresetn, // Reset, active low
    input logic s_axi_awvalid, // Write address valid
    input logic s_axi_awready, // Write address ready
    input logic s_axi_wvalid, // Write data valid
    input logic s_axi_wready, // Write data ready
    input logic [1:0] s_axi_bresp, // Write response
    input logic s_axi_bvalid, // Write response valid
    input logic s_axi_bready, // Write response ready
    input logic s_axi_arvalid, // Read address valid
    input logic s_axi_arready, // Read address ready
    input logic [31:0] s_axi_rdata, // Read data
    input logic [1:0] s_axi_rresp, // Read response
    input logic s_axi_rvalid, // Read data valid
    input logic s_axi_rready, // Read data ready
    input logic [CH-1:0] waveform_out, // Channel waveforms
    input logic overflow_flag // Overflow flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("read data late");
    chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read not blocked");
    chk_resp_code: assert property (s_axi_bvalid
        |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("bad write response code");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
    // Hardware only sets the flag, so a fall needs a write under way
    chk_ovf_clear: assert property ($fell(overflow_flag)
        |-> !s_axi_awready) else $error("flag cleared without a write");
    cover property ($rose(waveform_out[0]));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property ($fell(overflow_flag));
endmodule // hstw_assertions

bind hstw_top hstw_assertions #(.CH(CH)) u_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .waveform_out(waveform_out),
    .overflow_flag(overflow_flag)
);

// ===== sim/hstw_load.sv
// Load model that resolves one set of pin levels
`timescale 1ns/1ps
module hstw_load #(
    parameter CH = 3
) (
    input logic aclk, // Clock
    input logic [CH-1:0] drv_o, // Level offered by the block
    input logic [CH-1:0] drv_oe, // High while the block drives
    output logic [CH-1:0] pad // Level seen at the load
);
    // No pull on the pad, so a released pin never holds its last level
    logic [CH-1:0] float_r = {CH{1'b0}};
    assign pad = (drv_oe & drv_o) | (~drv_oe & float_r);
    always @(posedge aclk) begin
        float_r <= ~pad;
    end
endmodule // hstw_load

// ===== sim/hstw_top_tb.sv
// Register-level testbench for the timer waveform block
`timescale 1ns/1ps
`include "hstw_map.vh"
module hstw_top_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, overflow_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd_v, per, hi;
    logic [2:0] pin_true_o, pin_true_oe, pin_comp_o, pin_comp_oe;
    logic [2:0] waveform_out, pad_true, pad_comp;
    int n_errors = 0, checks = 0;
    always #12.5 aclk = ~aclk;
    hstw_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin_true_o(pin_true_o),
        .pin_true_oe(pin_true_oe), .pin_comp_o(pin_comp_o),
        .pin_comp_oe(pin_comp_oe), .waveform_out(waveform_out),
        .overflow_flag(overflow_flag));
    hstw_load u_load_t (.aclk(aclk), .drv_o(pin_true_o),
        .drv_oe(pin_true_oe), .pad(pad_true));
    hstw_load u_load_c (.aclk(aclk), .drv_o(pin_comp_o),
        .drv_oe(pin_comp_oe), .pad(pad_comp));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) n_errors++;
        chk(s_axi_bresp, er);
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) n_errors++;
        rd_v = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask
    // Clocks from one rising edge of waveform 0 to the next
    task meas;
        int n;
        logic p;
        n = 0;
        p = 1'b1;
        while (!(p === 1'b0 && waveform_out[0] === 1'b1) && n < 400) begin
            p = waveform_out[0];
            @(posedge aclk);
            n++;
        end
        per = 0;
        hi = 0;
        do begin
            if (waveform_out[0] === 1'b1) hi++;
            per++;
            p = waveform_out[0];
            @(posedge aclk);
        end while (!(p === 1'b0 && waveform_out[0] === 1'b1) && per < 400);
        if (n >= 400 || per >= 400) n_errors++;
    endtask
    task cfg(input logic [31:0] ctrl, input logic [31:0] top,
        input logic [31:0] cmp);
        wr(`HSTW_OFF_CTRL, 32'h0, 2'h0);
        wr(`HSTW_OFF_CNT, 32'h0, 2'h0);
        wr(`HSTW_OFF_TOP, top, 2'h0);
        wr(`HSTW_OFF_CMP0, cmp, 2'h0);
        wr(`HSTW_OFF_CTRL, ctrl, 2'h0);
        meas;
        meas;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`HSTW_OFF_TOP, 2'h0);
        chk(rd_v, 32'h0000_03FF);
        rd(8'h1C, 2'h2);
        chk(rd_v, 32'h0);
        wr(8'h1C, 32'hFFFF_FFFF, 2'h2);
        wr(`HSTW_OFF_PORT, 32'h0000_0101, 2'h0);
        wr(`HSTW_OFF_DIR, 32'h0000_0101, 2'h0);
        repeat (4) @(posedge aclk);
        chk(pad_true[0], 1'b1);
        cfg(32'h4, 32'h3, 32'h0001_0001);
        chk(per, 32'h8);
        chk(hi, 32'h4);
        chk(pin_true_oe[0], 1'b1);
        chk(pad_comp[0], 1'b1);
        chk(overflow_flag, 1'b1);
        for (int s = 2; s < 4; s++) begin
            wr(`HSTW_OFF_CMP0, (s << 16) | 1, 2'h0);
            repeat (20) @(posedge aclk);
            chk(waveform_out[0], s - 2);
        end
        wr(`HSTW_OFF_CTRL, 32'h0, 2'h0);
        wr(`HSTW_OFF_STAT, 32'h1, 2'h0);
        repeat (2) @(posedge aclk);
        chk(overflow_flag, 1'b0);
        wr(`HSTW_OFF_CNT, 32'h5, 2'h0);
        rd(`HSTW_OFF_CNT, 2'h0);
        chk(rd_v, 32'h5);
        for (int s = 1; s < 4; s++) begin
            cfg(32'h5, 32'h7, (s << 16) | 2);
            chk(per, 32'h8);
            chk(hi, (s == 3) ? 5 : 3);
            chk(pin_comp_oe[0], 1'b1);
            if (s == 1) chk(pin_comp_o[0] ^ pin_true_o[0], 1'b1);
            if (s > 1) chk(pin_comp_o[0], 1'b1);
        end
        cfg(32'h7, 32'h7, 32'h0002_0002);
        chk(per, 32'hE);
        chk(hi, 32'h4);
        wr(`HSTW_OFF_DIR, 32'h0, 2'h0);
        repeat (4) @(posedge aclk);
        chk(pin_true_oe[0], 1'b0);
        wrap_up;
    end
endmodule // hstw_top_tb
